// ==== hw/sta_regs.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 segmented trigger acquisition block. Assumes a 32-bit classic Wishbone
 slave decoding byte addresses.
*/
`ifndef STA_REGS_SVH
`define STA_REGS_SVH

`define STA_MODE_ADDR 16'h251c
`define STA_TOTAL_LO_ADDR 16'h2710
`define STA_TOTAL_HI_ADDR 16'h2714
`define STA_LOOPS_LO_ADDR 16'h2724
`define STA_LOOPS_HI_ADDR 16'h2728
`define STA_SEGLEN_ADDR 16'h2740
`define STA_POST_ADDR 16'h2744
`define STA_CTRL_ADDR 16'h2748
`define STA_STATUS_ADDR 16'h274c
`define STA_SEGDONE_ADDR 16'h2750
`define STA_PRE_ADDR 16'h2754

`define STA_MODE_STD_MULTI 32'h0000_0002
`define STA_MODE_FIFO_MULTI 32'h0000_0020

`define STA_CTRL_START_BIT 0
`define STA_CTRL_STOP_BIT 1
`define STA_CTRL_CH16_BIT 2

`define STA_STEP_LSB 5
`define STA_MIN_TOTAL 64'h0000_0000_0000_0040
`define STA_MIN_POST 32'h0000_0020
`define STA_MIN_SEG 32'h0000_0040

`define STA_RESET_MODE 32'h0000_0002
`define STA_RESET_SEGLEN 32'h0000_0040
`define STA_RESET_POST 32'h0000_0020
`define STA_RESET_TOTAL 64'h0000_0000_0000_0040

`define STA_REARM_NS 10
`define STA_CLK_MHZ 200

`endif

// ==== hw/sta_pkg.sv ====
/*
 Types shared by the segmented trigger acquisition block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sta_pkg;

	typedef enum logic [2:0] {
		STA_IDLE,
		STA_PRE,
		STA_ARMED,
		STA_POST,
		STA_REARM,
		STA_DONE
	} sta_state_e;

	typedef struct packed {
		logic [31:0] data;
		logic last;
	} sta_beat_s;

	typedef struct packed {
		logic running;
		logic done;
		logic armed;
		logic fifo_mode;
		logic bad_cfg;
	} sta_status_s;

endpackage

// ==== hw/sta_seg_acq.sv ====
/*
 Segmented trigger acquisition control: counts segments, gates samples into
 a two-entry output buffer and stops on total count or segment limit.
 Assumes samples and trigger come from logic on clk_i, one sample per
 enabled cycle, and a pre-event history ring sits upstream of sample_i.
*/
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`include "sta_regs.svh"

// Contract
// - Each trigger fills one segment, then the next trigger fills the next.
// - Segment length in samples comes from the segment length register.
// - Mode code 2 selects segmented acquisition into memory.
// - Mode code 32 selects segmented acquisition streamed to the host.
// - Memory mode records the programmed total count and then stops.
// - Streaming mode ignores the total count and runs until stopped or until its segment limit.
// - A zero segment limit streams until a stop command.
// - A nonzero segment limit ends streaming after that many segments.
// - Streaming sends only segment samples, never the gaps between them.
// - Total count maximum is the full memory at 8 and half at 16 channels.
// - Total count is at least 64 and post-event count at least 32.
// - Post-event count is the number of samples kept after the trigger.
// - Pre-event portion is the segment length minus the post-event count.
// - Each segment holds samples from before and after its trigger; post equal to seglen is accepted and leaves no pre-event samples.
module sta_seg_acq #(
	parameter logic [63:0] MEM_SAMPLES = 64'h0000_0001_0000_0000
)(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Samples and trigger
	input wire logic [31:0] sample_i,
	input wire logic trigger_i,
	// Segment data out
	output logic [31:0] out_data_o,
	output logic out_last_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	// Status
	output logic running_o,
	output logic done_o
);

	localparam int REARM_CYC_RAW = (`STA_REARM_NS * `STA_CLK_MHZ) / 1000;
	localparam int REARM_CYC = (REARM_CYC_RAW < 1) ? 1 : REARM_CYC_RAW;

	sta_pkg::sta_state_e state;
	sta_pkg::sta_status_s status;
	logic [31:0] mode;
	logic [63:0] total;
	logic [63:0] loops;
	logic [31:0] seglen;
	logic [31:0] post;
	logic ch16;
	logic [31:0] cnt;
	logic [63:0] recorded;
	logic [63:0] segs_done;
	logic [3:0] rearm_cnt;
	logic stop_req;
	logic start_req;
	logic fifo_mode;
	logic std_mode;
	logic [31:0] pre;
	logic [63:0] max_total;
	logic bad_cfg;
	logic in_seg;
	logic seg_end;
	logic limit_hit;
	logic wb_req;
	logic [31:0] next_rdata;
	sta_pkg::sta_beat_s buf0;
	sta_pkg::sta_beat_s buf1;
	logic [1:0] buf_cnt;
	logic in_ready;
	logic push;
	logic pop;

	assign std_mode = (mode == `STA_MODE_STD_MULTI);
	assign fifo_mode = (mode == `STA_MODE_FIFO_MULTI);
	assign pre = seglen - post;
	// Half the memory per channel once sixteen channels share it
	assign max_total = ch16 ? (MEM_SAMPLES >> 1) : MEM_SAMPLES;
	assign bad_cfg = (!std_mode && !fifo_mode)
		|| (std_mode && (total < `STA_MIN_TOTAL || total > max_total))
		|| post < `STA_MIN_POST || seglen < `STA_MIN_SEG
		|| post > seglen;
	assign in_seg = (state == sta_pkg::STA_PRE) || (state == sta_pkg::STA_ARMED)
		|| (state == sta_pkg::STA_POST);
	// Stall pre and post capture while the buffer is full; the armed trigger wait does not stall
	// Armed cycles are gap: only pre and post samples enter, seglen in all
	assign push = ce_i && in_ready && (state == sta_pkg::STA_POST
		|| (state == sta_pkg::STA_PRE && pre != 32'h0000_0000));
	assign seg_end = push && (state == sta_pkg::STA_POST) && (cnt == post - 1);
	assign limit_hit = fifo_mode ? (loops != 64'h0000_0000_0000_0000
		&& segs_done + 64'h0000_0000_0000_0001 >= loops)
		: (recorded + {32'h0000_0000, seglen} >= total);
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Acquisition sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= sta_pkg::STA_IDLE;
			cnt <= 32'h0000_0000;
			rearm_cnt <= 4'h0;
		end
		else if (ce_i)
		begin
			unique case (state)
				sta_pkg::STA_IDLE, sta_pkg::STA_DONE:
				begin
					if (start_req && !bad_cfg)
					begin
						state <= sta_pkg::STA_PRE;
						cnt <= 32'h0000_0000;
					end
				end
				sta_pkg::STA_PRE:
				begin
					// Pre-event samples lead the segment
					if (stop_req)
						state <= sta_pkg::STA_DONE;
					else if (push && cnt == pre - 1)
					begin
						state <= sta_pkg::STA_ARMED;
						cnt <= 32'h0000_0000;
					end
					else if (pre == 32'h0000_0000)
						state <= sta_pkg::STA_ARMED;
					else if (push)
						cnt <= cnt + 32'h0000_0001;
				end
				sta_pkg::STA_ARMED:
				begin
					// Waiting samples are dropped, never streamed
					if (stop_req)
						state <= sta_pkg::STA_DONE;
					else if (trigger_i)
					begin
						state <= sta_pkg::STA_POST;
						cnt <= 32'h0000_0000;
					end
				end
				sta_pkg::STA_POST:
				begin
					if (seg_end)
					begin
						cnt <= 32'h0000_0000;
						if (limit_hit || stop_req)
							state <= sta_pkg::STA_DONE;
						else
						begin
							state <= sta_pkg::STA_REARM;
							rearm_cnt <= 4'(REARM_CYC - 1);
						end
					end
					else if (push)
						cnt <= cnt + 32'h0000_0001;
				end
				sta_pkg::STA_REARM:
				begin
					// No software restart between segments
					if (stop_req)
						state <= sta_pkg::STA_DONE;
					else if (rearm_cnt == 4'h0)
						state <= sta_pkg::STA_PRE;
					else
						rearm_cnt <= rearm_cnt - 4'h1;
				end
			endcase
		end
	end

	// Segment and sample accounting
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			recorded <= 64'h0000_0000_0000_0000;
			segs_done <= 64'h0000_0000_0000_0000;
		end
		else if (ce_i)
		begin
			if (start_req && (state == sta_pkg::STA_IDLE
				|| state == sta_pkg::STA_DONE))
			begin
				recorded <= 64'h0000_0000_0000_0000;
				segs_done <= 64'h0000_0000_0000_0000;
			end
			else if (seg_end)
			begin
				recorded <= recorded + {32'h0000_0000, seglen};
				segs_done <= segs_done + 64'h0000_0000_0000_0001;
			end
		end
	end

	// Register writes; a pending stop survives until the run ends
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode <= `STA_RESET_MODE;
			total <= `STA_RESET_TOTAL;
			loops <= 64'h0000_0000_0000_0000;
			seglen <= `STA_RESET_SEGLEN;
			post <= `STA_RESET_POST;
			ch16 <= 1'b0;
			start_req <= 1'b0;
			stop_req <= 1'b0;
		end
		else if (ce_i)
		begin
			start_req <= 1'b0;
			if (state == sta_pkg::STA_DONE || state == sta_pkg::STA_IDLE)
				stop_req <= 1'b0;
			if (wb_req && wb_we_i && wb_sel_i == 4'hf)
			begin
				unique case (wb_adr_i)
					`STA_MODE_ADDR: mode <= wb_dat_i;
					`STA_TOTAL_LO_ADDR: total[31:0] <= wb_dat_i;
					`STA_TOTAL_HI_ADDR: total[63:32] <= wb_dat_i;
					`STA_LOOPS_LO_ADDR: loops[31:0] <= wb_dat_i;
					`STA_LOOPS_HI_ADDR: loops[63:32] <= wb_dat_i;
					`STA_SEGLEN_ADDR: seglen <= {wb_dat_i[31:5], 5'h00};
					`STA_POST_ADDR: post <= {wb_dat_i[31:5], 5'h00};
					`STA_CTRL_ADDR:
					begin
						start_req <= wb_dat_i[`STA_CTRL_START_BIT];
						stop_req <= wb_dat_i[`STA_CTRL_STOP_BIT];
						ch16 <= wb_dat_i[`STA_CTRL_CH16_BIT];
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	assign status.running = in_seg || (state == sta_pkg::STA_REARM);
	assign status.done = (state == sta_pkg::STA_DONE);
	assign status.armed = (state == sta_pkg::STA_ARMED);
	assign status.fifo_mode = fifo_mode;
	assign status.bad_cfg = bad_cfg;

	always_comb
	begin
		unique case (wb_adr_i)
			`STA_MODE_ADDR: next_rdata = mode;
			`STA_TOTAL_LO_ADDR: next_rdata = total[31:0];
			`STA_TOTAL_HI_ADDR: next_rdata = total[63:32];
			`STA_LOOPS_LO_ADDR: next_rdata = loops[31:0];
			`STA_LOOPS_HI_ADDR: next_rdata = loops[63:32];
			`STA_SEGLEN_ADDR: next_rdata = seglen;
			`STA_POST_ADDR: next_rdata = post;
			`STA_CTRL_ADDR: next_rdata = {29'h0000_0000, ch16, 2'h0};
			`STA_STATUS_ADDR: next_rdata = {27'h0000_0000, status};
			`STA_SEGDONE_ADDR: next_rdata = segs_done[31:0];
			`STA_PRE_ADDR: next_rdata = pre;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Bus answer: one wait state, ack dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			wb_ack_o <= wb_req;
			if (wb_req)
				wb_dat_o <= next_rdata;
		end
	end

	// Two-entry skid buffer between capture and host
	assign in_ready = (buf_cnt != 2'd2);
	assign pop = ce_i && out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			buf0 <= '0;
			buf1 <= '0;
			buf_cnt <= 2'd0;
			out_valid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			unique case ({push, pop})
				2'b10:
				begin
					if (buf_cnt == 2'd0)
						buf0 <= '{data: sample_i, last: seg_end};
					else
						buf1 <= '{data: sample_i, last: seg_end};
					buf_cnt <= buf_cnt + 2'd1;
					out_valid_o <= 1'b1;
				end
				2'b01:
				begin
					buf0 <= buf1;
					buf_cnt <= buf_cnt - 2'd1;
					out_valid_o <= (buf_cnt != 2'd1);
				end
				2'b11:
				begin
					if (buf_cnt == 2'd1)
						buf0 <= '{data: sample_i, last: seg_end};
					else
					begin
						buf0 <= buf1;
						buf1 <= '{data: sample_i, last: seg_end};
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	assign out_data_o = buf0.data;
	assign out_last_o = buf0.last;

	// Status outputs registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			running_o <= 1'b0;
			done_o <= 1'b0;
		end
		else if (ce_i)
		begin
			running_o <= status.running;
			done_o <= status.done;
		end
	end

	a_seg_post_len: assert property (@(posedge clk_i) disable iff (rst_i)
		seg_end |-> cnt == post - 1)
		else $error("segment ended at wrong post count");
	a_seg_count_up: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && seg_end |=> segs_done == $past(segs_done) + 1)
		else $error("segment count not advanced");
	a_rearm_gap: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && state == sta_pkg::STA_REARM && rearm_cnt == 0 && !stop_req
		|=> state == sta_pkg::STA_PRE)
		else $error("no re-arm after gap");
	a_std_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && seg_end && std_mode && limit_hit
		|=> state == sta_pkg::STA_DONE)
		else $error("memory mode did not stop at total");
	a_loop_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && fifo_mode && loops == 0 && seg_end && !stop_req
		|=> state == sta_pkg::STA_REARM)
		else $error("infinite stream stopped");
	a_no_gap_data: assert property (@(posedge clk_i) disable iff (rst_i)
		push |-> in_seg)
		else $error("sample pushed outside segment");
	a_pre_calc: assert property (@(posedge clk_i) disable iff (rst_i)
		pre + post == seglen)
		else $error("pre plus post differs from segment");
	a_cfg_min: assert property (@(posedge clk_i) disable iff (rst_i)
		state == sta_pkg::STA_IDLE && start_req && post < 32
		|=> state == sta_pkg::STA_IDLE)
		else $error("short post count accepted");

	c_seg_done: cover property (@(posedge clk_i) seg_end);
	c_run_done: cover property (@(posedge clk_i) state == sta_pkg::STA_DONE);
	c_stall: cover property (@(posedge clk_i) out_valid_o && !out_ready_i);

endmodule

// ==== sim/sta_far_model.sv ====
/*
 Far side of the acquisition block: sample and trigger source plus a
 stalling sink that counts segments. Assumes one clock shared with it.
*/
`timescale 1ns/100ps
module sta_far_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench control
	input wire logic trig_en_i,
	input wire logic clr_i,
	// Toward the block
	output logic [31:0] sample_o,
	output logic trigger_o,
	input wire logic out_last_i,
	input wire logic out_valid_i,
	output logic out_ready_o,
	// Statistics
	output logic [31:0] seg_cnt_o,
	output logic [31:0] beat_min_o,
	output logic [31:0] beat_max_o
);
	logic [31:0] beats;
	always_ff @(posedge clk_i)
	begin
		sample_o <= rst_i ? 32'h0000_0000 : sample_o + 32'h0000_0001;
		trigger_o <= trig_en_i;
		// Stall one cycle in four so the buffer fills
		out_ready_o <= (sample_o[1:0] != 2'h0);
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clr_i)
		begin
			seg_cnt_o <= 32'h0000_0000;
			beats <= 32'h0000_0000;
			beat_min_o <= 32'hffff_ffff;
			beat_max_o <= 32'h0000_0000;
		end
		else if (out_valid_i && out_ready_o)
		begin
			beats <= out_last_i ? 32'h0000_0000 : beats + 32'h0000_0001;
			if (out_last_i)
			begin
				seg_cnt_o <= seg_cnt_o + 32'h0000_0001;
				if (beats + 32'h0000_0001 < beat_min_o)
					beat_min_o <= beats + 32'h0000_0001;
				if (beats + 32'h0000_0001 > beat_max_o)
					beat_max_o <= beats + 32'h0000_0001;
			end
		end
	end
endmodule

// ==== sim/segmented_trigger_acquisition_bench.sv ====
/*
 Self-checking bench: Wishbone register tasks and acquisition runs.
 Assumes the far-side model and the register header are compiled.
*/
`timescale 1ns/100ps
`include "sta_regs.svh"
module segmented_trigger_acquisition_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic trig_en = 1'b0;
	logic clr = 1'b0;
	logic [31:0] wb_dat_o, sample, seg_cnt, bmin, bmax, q;
	logic wb_ack_o, trigger, last, valid, ready, running_o, done_o;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int i;
	always #2.5 clk_i = ~clk_i;
	sta_seg_acq #(.MEM_SAMPLES(64'h0000_0000_0000_1000)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sample_i(sample), .trigger_i(trigger),
		.out_data_o(), .out_last_o(last), .out_valid_o(valid),
		.out_ready_i(ready), .running_o(running_o), .done_o(done_o));
	sta_far_model far (
		.clk_i(clk_i), .rst_i(rst_i), .trig_en_i(trig_en), .clr_i(clr),
		.sample_o(sample), .trigger_o(trigger), .out_last_i(last),
		.out_valid_i(valid), .out_ready_o(ready), .seg_cnt_o(seg_cnt),
		.beat_min_o(bmin), .beat_max_o(bmax));
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk32(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	// Classic cycle: hold everything until ack is sampled high
	task automatic wb_cycle(input logic [15:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		q = wb_dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		wb_cycle(a, 1'b1, d, 4'hf);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e,
		input string n);
		wb_cycle(a, 1'b0, 32'h0000_0000, 4'hf);
		chk32(n, e, q);
	endtask
	task automatic start_run();
		@(posedge clk_i);
		clr <= 1'b1;
		trig_en <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		wr(`STA_CTRL_ADDR, 32'h0000_0001);
		for (i = 0; i < 50 && running_o !== 1'b1; i++)
			@(posedge clk_i);
	endtask
	task automatic wait_done();
		for (i = 0; i < 4000 && done_o !== 1'b1; i++)
			@(posedge clk_i);
		// Let the last beats drain from the buffer
		repeat (8) @(posedge clk_i);
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			summarize();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`STA_MODE_ADDR, `STA_MODE_STD_MULTI, "mode reset");
		rd(`STA_SEGLEN_ADDR, `STA_RESET_SEGLEN, "seglen reset");
		rd(`STA_POST_ADDR, `STA_RESET_POST, "post reset");
		rd(`STA_TOTAL_LO_ADDR, 32'h0000_0040, "total reset");
		rd(`STA_LOOPS_LO_ADDR, 32'h0000_0000, "loops reset");
		rd(16'h2000, 32'h0000_0000, "unmapped");
		wb_cycle(`STA_MODE_ADDR, 1'b1, `STA_MODE_FIFO_MULTI, 4'h3);
		rd(`STA_MODE_ADDR, `STA_MODE_STD_MULTI, "partial write");
		$display("test registers done");
		wr(`STA_SEGLEN_ADDR, 32'h0000_009f);
		rd(`STA_SEGLEN_ADDR, 32'h0000_0080, "seglen step");
		wr(`STA_POST_ADDR, 32'h0000_0040);
		rd(`STA_PRE_ADDR, 32'h0000_0040, "pre length");
		wr(`STA_TOTAL_LO_ADDR, 32'h0000_1000);
		wr(`STA_CTRL_ADDR, 32'h0000_0004);
		rd(`STA_STATUS_ADDR, 32'h0000_0001, "16 ch limit");
		wr(`STA_CTRL_ADDR, 32'h0000_0005);
		repeat (4) @(posedge clk_i);
		chk32("start refused", 32'h0, {31'h0, running_o});
		wr(`STA_CTRL_ADDR, 32'h0000_0000);
		rd(`STA_STATUS_ADDR, 32'h0000_0000, "8 ch limit");
		wr(`STA_TOTAL_LO_ADDR, 32'h0000_0020);
		rd(`STA_STATUS_ADDR, 32'h0000_0001, "total min");
		$display("test limits done");
		wr(`STA_TOTAL_LO_ADDR, 32'h0000_0180);
		start_run();
		wait_done();
		chk32("std segments", 32'h3, seg_cnt);
		chk32("std done", 32'h1, {31'h0, done_o});
		chk32("beats min", 32'h80, bmin);
		chk32("beats max", 32'h80, bmax);
		rd(`STA_SEGDONE_ADDR, 32'h0000_0003, "segments done");
		repeat (300) @(posedge clk_i);
		chk32("after stop", 32'h3, seg_cnt);
		$display("test standard done");
		wr(`STA_MODE_ADDR, `STA_MODE_FIFO_MULTI);
		wr(`STA_LOOPS_LO_ADDR, 32'h0000_0002);
		start_run();
		wait_done();
		chk32("fifo segments", 32'h2, seg_cnt);
		chk32("fifo beats", 32'h80, bmax);
		rd(`STA_SEGDONE_ADDR, 32'h0000_0002, "fifo done count");
		rd(`STA_STATUS_ADDR, 32'h0000_000a, "fifo status");
		$display("test fifo limit done");
		wr(`STA_LOOPS_LO_ADDR, 32'h0000_0000);
		start_run();
		for (i = 0; i < 4000 && seg_cnt < 32'h5; i++)
			@(posedge clk_i);
		chk32("endless run", 32'h1, {31'h0, running_o});
		wr(`STA_CTRL_ADDR, 32'h0000_0002);
		for (i = 0; i < 1000 && running_o !== 1'b0; i++)
			@(posedge clk_i);
		chk32("stopped", 32'h0, {31'h0, running_o});
		$display("test fifo endless done");
		summarize();
	end
endmodule
